// ==== rtl/fbm_defines.svh ====
/*
 Timing counts, register offsets, field positions and flash map constants
 for the flash BIOS map controller. Assumes a 10 MHz system clock.
*/
`ifndef FBM_DEFINES_SVH
`define FBM_DEFINES_SVH
// Clock and timing
`define FBM_CLK_NS 100
`define FBM_T_ACCESS_NS 250
`define FBM_ACCESS_CYC ((`FBM_T_ACCESS_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_T_VPP_SETTLE_US 100
`define FBM_VPP_SETTLE_CYC ((`FBM_T_VPP_SETTLE_US * 1000 + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_SYNC_CYC 2
// Register byte offsets
`define FBM_REG_CTRL 8'h00
`define FBM_REG_ADDR 8'h04
`define FBM_REG_CMD 8'h08
`define FBM_REG_STATUS 8'h0C
`define FBM_REG_RDATA 8'h10
// Control bits
`define FBM_CTRL_VPP_ON 0
`define FBM_CTRL_VPP_5V 1
`define FBM_CTRL_BOOT_UNLOCK 2
`define FBM_CTRL_WR_GATE 3
`define FBM_CTRL_RUNTIME 4
`define FBM_CTRL_INVERT 5
`define FBM_CTRL_WP_UNLOCK 6
`define FBM_CTRL_SYS_RESET 7
`define FBM_CTRL_W 7
`define FBM_CTRL_RST 7'h00
// Command bits
`define FBM_CMD_WRITE 8
// Status bits
`define FBM_ST_BUSY 0
`define FBM_ST_VPP_READY 1
`define FBM_ST_SUPPLY_OK 2
`define FBM_ST_INVERT 3
`define FBM_ST_REFUSED 4
`define FBM_ST_TOP_LINE 5
// Physical BIOS window and flash layout
`define FBM_BIOS_BASE 20'hE_0000
`define FBM_KERNEL_BASE 20'hF_E000
`define FBM_BOOT_TOP_BASE 18'h3_C000
`define FBM_BOOT_SIZE 18'h0_4000
`define FBM_PARAM_SIZE 18'h0_2000
`define FBM_MAIN0_SIZE 18'h1_8000
`define FBM_MAIN1_SIZE 18'h2_0000
`endif

// ==== rtl/fbm_pkg.sv ====
/*
 Types for the flash BIOS map controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fbm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_CAPTURE,
		ST_RECOVER
	} fbm_state_t;
endpackage

// ==== rtl/fbm_sync.sv ====
/*
 Two-flop synchroniser, one per bit.
 Assumes inputs are asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module fbm_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_r;
			logic sync_r;
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= din[i];
					sync_r <= meta_r;
				end
			end
			assign dout[i] = sync_r;
		end
	endgenerate
endmodule // fbm_sync
`default_nettype wire

// ==== rtl/fbm_addr_map.sv ====
/*
 Maps a physical BIOS address onto the flash address lines.
 Assumes a 2-Mbit part with eighteen byte address lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_addr_map #(
	parameter bit BOOT_AT_TOP = 1'b1
) (
	// Request
	input wire logic [19:0] phys_addr,
	input wire logic runtime_mode,
	input wire logic invert,
	// Result
	output logic in_window,
	output logic [17:0] flash_addr,
	output logic in_boot_block
);
	logic top_line;
	// Boot mode shows the upper half, runtime the lower; recovery flips it
	assign top_line = ~runtime_mode ^ invert; // R13 R14 R15
	assign in_window = (phys_addr >= `FBM_BIOS_BASE); // R11 R12
	assign flash_addr = {top_line, phys_addr[16:0]};
	// Boot block sits at either end of the part
	assign in_boot_block = BOOT_AT_TOP ? (flash_addr >= `FBM_BOOT_TOP_BASE)
		: (flash_addr < `FBM_BOOT_SIZE); // R01 R02
endmodule // fbm_addr_map
`default_nettype wire

// ==== rtl/fbm_ctrl.sv ====
/*
 Host-side glue for a boot-block flash BIOS: AXI4-Lite registers, flash
 bus cycles, program supply and reset/power-down control, address swap.
 Assumes asynchronous flash pins, switch and jumper; one 10 MHz clock.
*/
// How it works
// R01 - Five blocks: boot, two parameter, two main
// R02 - Boot block at top or bottom
// R03 - Boot block writable only with high unlock; the code also unlocks it with the logic write-protect bit
// R04 - Write enable gates every flash write
// R05 - Standard part programs at twelve volts
// R06 - Low-voltage part programs at twelve or five
// R07 - Five-volt supply range is 4.5 to 5.5
// R08 - Logic write-protect pin unlocks boot block
// R09 - Raise program supply first, lower afterwards
// R10 - Reset pin gated by supply valid
// R11 - Boot mode fetches kernel at FE000h
// R12 - Runtime maps main BIOS at E0000h
// R13 - Glue swaps upper and lower halves
// R14 - Runtime drives top address line low
// R15 - Recovery inverts the top address line
// R16 - Keyboard, switch or jumper controls inversion
// R17 - Recovery erases non-boot blocks, then resets
// R18 - No reads while programming another block
// R19 - Erase may be suspended for reads
// R20 - Recovery code runs from RAM
// R21 - Low supply: program and erase ignored
// R22 - Write enable only on memory writes
// R23 - Device resets into read-array mode
// R24 - Change inversion only between accesses
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defines.svh"
module fbm_ctrl #(
	parameter bit BOOT_AT_TOP = 1'b1,
	parameter int ACCESS_CYC = `FBM_ACCESS_CYC,
	parameter int VPP_SETTLE_CYC = `FBM_VPP_SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Flash bus
	output logic [17:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic [7:0] flash_dq_i,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	// Flash protection and supply
	output logic reset_powerdown_pin,
	output logic reset_powerdown_hv_en,
	output logic write_protect_n,
	output logic program_supply_en,
	output logic program_supply_5v,
	// Board
	input wire logic supply_valid_signal,
	input wire logic recovery_switch,
	input wire logic recovery_jumper,
	output logic sys_reset_req
);
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int CNT_W = 16;

	logic [10:0] pins_sync;
	logic [7:0] dq_sync;
	logic supply_ok;
	logic switch_s;
	logic jumper_s;

	fbm_sync #(.WIDTH(11)) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din({flash_dq_i, supply_valid_signal, recovery_switch, recovery_jumper}),
		.dout(pins_sync)
	);
	assign dq_sync = pins_sync[10:3];
	assign supply_ok = pins_sync[2];
	assign switch_s = pins_sync[1];
	assign jumper_s = pins_sync[0];

	// Register and sequencer state
	fbm_pkg::fbm_state_t state_r, state_nxt;
	logic [`FBM_CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [8:0] cmd_r, cmd_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic refused_r, refused_nxt;
	logic invert_r, invert_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [CNT_W-1:0] vpp_cnt_r, vpp_cnt_nxt;
	logic reset_req_r, reset_req_nxt;
	logic [17:0] fa_r, fa_nxt;
	// Bus state
	logic aw_got_r, aw_got_nxt;
	logic w_got_r, w_got_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] axi_rdata_r, axi_rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic map_in_window;
	logic map_in_boot;
	logic [17:0] map_fa;
	logic vpp_ready;
	logic boot_unlocked;
	logic invert_src;
	logic wr_do;
	logic cmd_write;
	logic [31:0] status_word;

	fbm_addr_map #(.BOOT_AT_TOP(BOOT_AT_TOP)) u_map (
		.phys_addr(addr_r),
		.runtime_mode(ctrl_r[`FBM_CTRL_RUNTIME]),
		.invert(invert_r),
		.in_window(map_in_window),
		.flash_addr(map_fa),
		.in_boot_block(map_in_boot)
	);

	assign vpp_ready = ctrl_r[`FBM_CTRL_VPP_ON] && (vpp_cnt_r == CNT_W'(VPP_SETTLE_CYC));
	// High-voltage unlock or logic write-protect unlock
	assign boot_unlocked = (ctrl_r[`FBM_CTRL_BOOT_UNLOCK] && supply_ok)
		|| ctrl_r[`FBM_CTRL_WP_UNLOCK]; // R03 R08
	assign invert_src = ctrl_r[`FBM_CTRL_INVERT] | switch_s | jumper_s; // R16
	assign cmd_write = cmd_r[`FBM_CMD_WRITE];
	assign wr_do = aw_got_r && w_got_r && !bvalid_r;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`FBM_ST_BUSY] = (state_r != fbm_pkg::ST_IDLE);
		status_word[`FBM_ST_VPP_READY] = vpp_ready;
		status_word[`FBM_ST_SUPPLY_OK] = supply_ok;
		status_word[`FBM_ST_INVERT] = invert_r;
		status_word[`FBM_ST_REFUSED] = refused_r;
		status_word[`FBM_ST_TOP_LINE] = map_fa[17];
	end

	// AXI4-Lite slave
	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		axi_rdata_nxt = axi_rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (wr_do) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			unique case (awaddr_r)
				`FBM_REG_CTRL, `FBM_REG_ADDR, `FBM_REG_CMD, `FBM_REG_STATUS: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (s_axi_araddr)
				`FBM_REG_CTRL: axi_rdata_nxt = {25'h000_0000, ctrl_r};
				`FBM_REG_ADDR: axi_rdata_nxt = {12'h000, addr_r};
				`FBM_REG_CMD: axi_rdata_nxt = {23'h00_0000, cmd_r};
				`FBM_REG_STATUS: axi_rdata_nxt = status_word;
				`FBM_REG_RDATA: axi_rdata_nxt = {24'h00_0000, rdata_r};
				default: begin
					axi_rdata_nxt = 32'h0000_0000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = axi_rdata_r;
	assign s_axi_rresp = rresp_r;

	// Registers and flash cycle sequencer
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		addr_nxt = addr_r;
		cmd_nxt = cmd_r;
		rdata_nxt = rdata_r;
		refused_nxt = refused_r;
		invert_nxt = invert_r;
		cnt_nxt = cnt_r;
		fa_nxt = fa_r;
		reset_req_nxt = 1'b0;
		vpp_cnt_nxt = vpp_cnt_r;
		// Settle timer runs while supply is raised
		if (!ctrl_r[`FBM_CTRL_VPP_ON]) begin
			vpp_cnt_nxt = '0; // R09
		end else if (!vpp_ready) begin
			vpp_cnt_nxt = vpp_cnt_r + CNT_W'(1);
		end
		if (wr_do && (wstrb_r != 4'h0) && (state_r == fbm_pkg::ST_IDLE)) begin
			unique case (awaddr_r)
				`FBM_REG_CTRL: begin
					ctrl_nxt = wdata_r[`FBM_CTRL_W-1:0];
					reset_req_nxt = wdata_r[`FBM_CTRL_SYS_RESET]; // R17
				end
				`FBM_REG_ADDR: addr_nxt = wdata_r[19:0];
				`FBM_REG_CMD: begin
					cmd_nxt = wdata_r[8:0];
					state_nxt = fbm_pkg::ST_SETUP;
				end
				default: begin
				end
			endcase
		end
		if (wr_do && (wstrb_r != 4'h0) && awaddr_r == `FBM_REG_STATUS
				&& wdata_r[`FBM_ST_REFUSED]) begin
			refused_nxt = 1'b0;
		end
		unique case (state_r)
			fbm_pkg::ST_IDLE: begin
				invert_nxt = invert_src; // R24
			end
			fbm_pkg::ST_SETUP: begin
				fa_nxt = map_fa;
				cnt_nxt = '0;
				if (!map_in_window) begin
					refused_nxt = 1'b1;
					state_nxt = fbm_pkg::ST_IDLE;
				end else if (cmd_write && (!ctrl_r[`FBM_CTRL_WR_GATE]
						|| (map_in_boot && !boot_unlocked))) begin
					refused_nxt = 1'b1; // R04 R03 R17
					state_nxt = fbm_pkg::ST_IDLE;
				end else if (!cmd_write || !ctrl_r[`FBM_CTRL_VPP_ON] || vpp_ready) begin
					state_nxt = fbm_pkg::ST_STROBE; // R09 R21
				end
			end
			fbm_pkg::ST_STROBE: begin
				cnt_nxt = cnt_r + CNT_W'(1);
				if (cnt_r == CNT_W'(ACCESS_CYC - 1)) begin
					cnt_nxt = '0;
					state_nxt = cmd_write ? fbm_pkg::ST_RECOVER : fbm_pkg::ST_CAPTURE;
				end
			end
			fbm_pkg::ST_CAPTURE: begin
				// Output enable held while data crosses the synchroniser
				cnt_nxt = cnt_r + CNT_W'(1);
				if (cnt_r == CNT_W'(`FBM_SYNC_CYC)) begin
					rdata_nxt = dq_sync;
					state_nxt = fbm_pkg::ST_RECOVER;
				end
			end
			fbm_pkg::ST_RECOVER: begin
				state_nxt = fbm_pkg::ST_IDLE;
			end
			default: state_nxt = fbm_pkg::ST_IDLE;
		endcase
		if (wr_do && (state_r != fbm_pkg::ST_IDLE) && awaddr_r != `FBM_REG_STATUS) begin
			refused_nxt = 1'b1; // R20
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= fbm_pkg::ST_IDLE;
			ctrl_r <= `FBM_CTRL_RST;
			addr_r <= 20'h0_0000;
			cmd_r <= 9'h000;
			rdata_r <= 8'h00;
			refused_r <= 1'b0;
			invert_r <= 1'b0;
			cnt_r <= '0;
			vpp_cnt_r <= '0;
			reset_req_r <= 1'b0;
			fa_r <= 18'h0_0000;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'b00;
			rvalid_r <= 1'b0;
			axi_rdata_r <= 32'h0000_0000;
			rresp_r <= 2'b00;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			addr_r <= addr_nxt;
			cmd_r <= cmd_nxt;
			rdata_r <= rdata_nxt;
			refused_r <= refused_nxt;
			invert_r <= invert_nxt;
			cnt_r <= cnt_nxt;
			vpp_cnt_r <= vpp_cnt_nxt;
			reset_req_r <= reset_req_nxt;
			fa_r <= fa_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			axi_rdata_r <= axi_rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Flash pins
	logic in_strobe;
	assign in_strobe = (state_r == fbm_pkg::ST_STROBE);
	assign flash_addr = fa_r;
	assign flash_ce_n = !(in_strobe || state_r == fbm_pkg::ST_CAPTURE);
	assign flash_oe_n = !(!cmd_write && (in_strobe || state_r == fbm_pkg::ST_CAPTURE));
	assign flash_we_n = !(cmd_write && in_strobe); // R22 R04
	assign flash_dq_o = cmd_r[7:0];
	assign flash_dq_oe = cmd_write && (in_strobe || state_r == fbm_pkg::ST_RECOVER);
	assign reset_powerdown_pin = supply_ok && !reset_req_r; // R10
	assign reset_powerdown_hv_en = supply_ok && ctrl_r[`FBM_CTRL_BOOT_UNLOCK]; // R10 R03
	assign write_protect_n = ctrl_r[`FBM_CTRL_WP_UNLOCK]; // R08
	assign program_supply_en = ctrl_r[`FBM_CTRL_VPP_ON]; // R09 R05
	assign program_supply_5v = ctrl_r[`FBM_CTRL_VPP_5V]; // R06 R07
	assign sys_reset_req = reset_req_r;
endmodule // fbm_ctrl
`default_nettype wire

// ==== dv/fbm_ctrl_properties.sv ====
/*
 Port assertions for the flash BIOS map controller.
 Bound into fbm_ctrl; one clock domain, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fbm_ctrl_properties #(
	parameter int ACCESS_CYC = 3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI responses
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Flash bus
	input wire logic [17:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic flash_dq_oe,
	// Protection and board
	input wire logic reset_powerdown_pin,
	input wire logic reset_powerdown_hv_en,
	input wire logic supply_valid_signal,
	input wire logic sys_reset_req
);
	logic [7:0] we_cnt_r;
	logic [7:0] we_cnt_nxt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Length of the running write strobe
	always_comb begin
		we_cnt_nxt = flash_we_n ? 8'h00 : we_cnt_r + 8'h01;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			we_cnt_r <= 8'h00;
		end else begin
			we_cnt_r <= we_cnt_nxt;
		end
	end
	a_write_strobe_shape: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write strobe without chip enable or data drive");
	a_write_strobe_len: assert property ($rose(flash_we_n) |-> we_cnt_r == ACCESS_CYC && flash_ce_n)
		else $error("write strobe length wrong");
	a_read_no_drive: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n && !flash_dq_oe)
		else $error("read strobe overlaps a write");
	a_addr_steady: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
		else $error("flash address moved inside a cycle");
	a_supply_gates_pin: assert property (!supply_valid_signal [*4] |->
		!reset_powerdown_hv_en && !reset_powerdown_pin)
		else $error("reset pin driven without valid supply");
	a_reset_one_pulse: assert property (sys_reset_req |=> !sys_reset_req)
		else $error("system reset request longer than one cycle");
	a_bresp_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rresp_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	cover property ($rose(flash_we_n));
	cover property (!flash_oe_n);
	cover property (sys_reset_req);
endmodule // fbm_ctrl_properties
bind fbm_ctrl fbm_ctrl_properties #(.ACCESS_CYC(ACCESS_CYC)) u_fbm_ctrl_properties (.*);
`default_nettype wire

// ==== dv/fbm_flash_model.sv ====
/*
 Behavioural boot-block flash: a write strobe with usable program supply programs one byte, boot block only when unlocked.
 Driven by the fbm_ctrl flash pins; unwritten bytes read a fixed pattern.
*/
`timescale 1ns/1ps
`default_nettype none
module fbm_flash_model #(
	parameter bit BOOT_AT_TOP = 1'b1,
	parameter bit LOW_VOLT = 1'b1
) (
	// Flash bus
	input wire logic [17:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	output logic [7:0] flash_dq_i,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_dq_oe,
	// Protection and supply
	input wire logic reset_powerdown_pin,
	input wire logic reset_powerdown_hv_en,
	input wire logic write_protect_n,
	input wire logic program_supply_en,
	input wire logic program_supply_5v
);
	logic [7:0] mem [int];
	logic [7:0] rd;
	logic boot, prog_ok, boot_ok;
	function automatic logic [7:0] pat(input logic [17:0] a);
		return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
	endfunction
	// Top or bottom 16 KB is the boot block, the rest is open
	assign boot = (flash_addr[17:14] == (BOOT_AT_TOP ? 4'hF : 4'h0));
	// 12 V always, 5 V only on the low-voltage part
	assign prog_ok = program_supply_en && (!program_supply_5v || LOW_VOLT);
	assign boot_ok = (reset_powerdown_hv_en && reset_powerdown_pin) || (LOW_VOLT && write_protect_n);
	// Released bus shows the inverse, never a stale copy
	assign flash_dq_i = (!flash_ce_n && !flash_oe_n && reset_powerdown_pin) ? rd : ~rd;
	always @(flash_addr) begin
		rd = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : pat(flash_addr);
	end
	always @(posedge flash_we_n) begin
		if (flash_dq_oe && reset_powerdown_pin && prog_ok && (!boot || boot_ok)) begin
			mem[int'(flash_addr)] = flash_dq_o;
			rd = flash_dq_o;
		end
	end
endmodule // fbm_flash_model
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 Self-checking bench: fbm_ctrl driven over AXI4-Lite, flash model on its pins.
 Assumes the defines header and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defines.svh"
module testbench;
	logic clk_sys, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, flash_dq_i, flash_dq_o, cv [5];
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, inv;
	logic [17:0] flash_addr, fa;
	logic [19:0] pa;
	logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, reset_powerdown_pin, rt;
	logic reset_powerdown_hv_en, write_protect_n, program_supply_en, program_supply_5v;
	logic supply_valid_signal, recovery_switch, recovery_jumper, sys_reset_req;
	int failures, compares, pulses;
	fbm_ctrl #(.ACCESS_CYC(3), .VPP_SETTLE_CYC(4)) u_fbm_ctrl (.*);
	fbm_flash_model u_fbm_flash_model (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		pulses <= pulses + int'(sys_reset_req === 1'b1);
	end
	function automatic logic [7:0] pat(input logic [17:0] a);
		return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Every decision taken on the rising edge that also completes the handshake
	task axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One flash cycle, wait for idle, then fetch read data
	task fl(input logic [19:0] p, input logic [8:0] c);
		axw(`FBM_REG_ADDR, {12'h000, p});
		axw(`FBM_REG_CMD, {23'h0, c});
		do axr(`FBM_REG_STATUS); while (d[`FBM_ST_BUSY] !== 1'b0);
		axr(`FBM_REG_RDATA);
	endtask
	task test_done;
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		failures++;
		test_done();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, compares, pulses} = '0;
		s_axi_wstrb = 4'hF;
		supply_valid_signal = 1'b1;
		{recovery_switch, recovery_jumper} = 2'b00;
		cv = '{8'h19, 8'h18, 8'h1B, 8'h49, 8'h0D};
		resetn = 1'b0;
		void'($urandom(32'hb94999ea));
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		axr(`FBM_REG_CTRL);
		chk(d, 32'h0000_0000);
		axr(`FBM_REG_STATUS);
		chk(d, 32'h0000_0024);
		axr(8'h14);
		chk({d[31:2], r}, 32'h0000_0002);
		axw(8'h18, 32'h0000_0000);
		chk({30'h0, r}, 32'h0000_0002);
		// Write with no byte lanes is answered but changes nothing
		s_axi_wstrb <= 4'h0;
		axw(`FBM_REG_CTRL, 32'h0000_0010);
		s_axi_wstrb <= 4'hF;
		chk({30'h0, r}, 32'h0000_0000);
		axr(`FBM_REG_CTRL);
		chk(d, 32'h0000_0000);
		$display("Reset and map test done");
		for (int i = 0; i < 16; i++) begin
			{inv, rt} = 3'(i);
			pa = {3'h7, 17'($urandom)};
			axw(`FBM_REG_CTRL, {26'h0, inv == 2'd1, rt, 4'h0});
			recovery_switch <= (inv == 2'd2);
			recovery_jumper <= (inv == 2'd3);
			fl(pa, 9'h000);
			chk(d, {24'h0, pat({~rt ^ (inv != 2'd0), pa[16:0]})});
		end
		{recovery_switch, recovery_jumper} <= 2'b00;
		$display("Window test done");
		for (int k = 0; k < 3; k++) begin
			pa = (k == 0) ? 20'h0_1000 : (k == 1) ? {3'h7, 17'($urandom)} : {6'h3F, 14'($urandom)};
			axw(`FBM_REG_CTRL, (k == 1) ? 32'h0000_0001 : 32'h0000_0009);
			fl(pa, 9'h15A);
			axr(`FBM_REG_STATUS);
			chk({31'h0, d[`FBM_ST_REFUSED]}, 32'h0000_0001);
			axw(`FBM_REG_STATUS, 32'h0000_0010);
			axr(`FBM_REG_STATUS);
			chk({31'h0, d[`FBM_ST_REFUSED]}, 32'h0000_0000);
			if (k > 0) begin
				fl(pa, 9'h000);
				chk(d, {24'h0, pat({1'b1, pa[16:0]})});
			end
		end
		$display("Refusal test done");
		for (int c = 0; c < 5; c++) begin
			pa = (c > 2) ? {6'h3F, 14'($urandom)} : {3'h7, 17'($urandom)};
			fa = {~cv[c][4], pa[16:0]};
			axw(`FBM_REG_CTRL, {24'h0, cv[c]});
			fl(pa, {1'b1, ~pat(fa)});
			fl(pa, 9'h000);
			chk(d, {24'h0, (c == 1) ? pat(fa) : ~pat(fa)});
		end
		axw(`FBM_REG_CTRL, 32'h0000_0004);
		chk({31'h0, program_supply_en}, 32'h0000_0000);
		chk({31'h0, reset_powerdown_hv_en}, 32'h0000_0001);
		$display("Program test done");
		axw(`FBM_REG_CTRL, 32'h0000_0084);
		repeat (4) @(posedge clk_sys);
		chk(pulses, 32'h0000_0001);
		supply_valid_signal <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk({30'h0, reset_powerdown_pin, reset_powerdown_hv_en}, 32'h0000_0000);
		supply_valid_signal <= 1'b1;
		repeat (4) @(posedge clk_sys);
		$display("Reset pin test done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
